// ==== rtl/rss_pkg.sv ====
// package of constants and types for the relay self-supervision block
package rss_pkg;
    localparam int unsigned CLK_HZ         = 125000000;        // core clock rate
    localparam int unsigned WDOG_TIMEOUT_US = 1000;            // watchdog timeout, microseconds
    localparam int unsigned WDOG_CYCLES    = WDOG_TIMEOUT_US * (CLK_HZ / 1000000);
    localparam int unsigned CYC_PERIOD_US  = 100;              // trip channel test step, us
    localparam int unsigned CYC_CYCLES     = CYC_PERIOD_US * (CLK_HZ / 1000000);
    localparam int unsigned FB_SETTLE      = 16;               // feedback settle cycles
    localparam int unsigned MAX_RESETS     = 3;                // reset attempts before lockout
    localparam int unsigned SAMPLE_W       = 16;               // current sample width
    localparam int unsigned FACTOR_W       = 8;                // summation factor width
    localparam int unsigned FACTOR_FRAC    = 6;                // fractional bits of factor
    localparam int unsigned NUM_CH         = 4;                // current channels
    localparam int unsigned NUM_TRIP       = 2;                // trip relays
    localparam int unsigned NUM_CMD        = 2;                // command channels per relay
    // register offsets
    localparam logic [7:0] ADDR_STATUS     = 8'h00;            // sticky fault status, ro
    localparam logic [7:0] ADDR_CLEAR      = 8'h04;            // write one to clear, wo
    localparam logic [7:0] ADDR_ENABLE     = 8'h08;            // interrupt enable
    localparam logic [7:0] ADDR_SUMTOL     = 8'h0c;            // zero-sum tolerance
    localparam logic [7:0] ADDR_ASYMTH     = 8'h10;            // asymmetry threshold
    localparam logic [7:0] ADDR_FACTOR     = 8'h14;            // four packed factors
    localparam logic [7:0] ADDR_WDKICK     = 8'h18;            // watchdog service
    localparam logic [7:0] ADDR_STATE      = 8'h1c;            // live state, ro
    localparam logic [7:0] ADDR_CRCREF     = 8'h20;            // reference checksum base
    // status bit positions
    localparam int unsigned ST_SUPPLY      = 0;
    localparam int unsigned ST_TRIPCH      = 1;
    localparam int unsigned ST_ZSUM        = 2;
    localparam int unsigned ST_ASYM        = 3;
    localparam int unsigned ST_MEM         = 4;
    localparam int unsigned ST_WDOG        = 5;
    localparam int unsigned ST_LOCK        = 6;
    localparam int unsigned ST_W           = 7;
    localparam logic [31:0] WDKICK_KEY     = 32'h0000a5c3;     // service key
    localparam logic [SAMPLE_W-1:0] SUMTOL_RST = 16'h0040;     // default tolerance
    localparam logic [SAMPLE_W-1:0] ASYMTH_RST = 16'h0400;     // default threshold
    localparam logic [31:0] FACTOR_RST     = 32'h40404040;     // unity factors
    // register bus carrier
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } rss_bus_t;
    // per-channel sample carrier
    typedef struct packed {
        logic                        valid;
        logic [NUM_CH*SAMPLE_W-1:0]  data;
    } rss_samp_t;
endpackage

// ==== rtl/rss_trip_chan.sv ====
// one trip relay: command and release gating with cyclic test fault detection
`timescale 1ns/1ps
module rss_trip_chan #(
    parameter int unsigned SETTLE = rss_pkg::FB_SETTLE
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       trip_req,      // protection trip request
    input  wire logic       block,         // protection blocked
    input  wire logic [1:0] test_pulse,    // test excitation per command channel
    input  wire logic [1:0] feedback,      // synchronised channel feedback
    output logic      [1:0] cmd_out,       // two command channels
    output logic            release_out,   // release channel
    output logic            fault          // channel or coil fault, sticky
);
    logic [1:0] cmd_q;                      // command channel drive
    logic       rel_q;                      // release channel drive
    logic       fault_q;                    // fault latch
    logic [$clog2(SETTLE+1)-1:0] settle_q;  // settle counter while excited
    logic [1:0] exc_q;                      // channels under test

    // drive: a trip needs both command and release paths, fault blocks output
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmd_q <= 2'h0;
            rel_q <= 1'b0;
        end else if (clk_en) begin
            if (trip_req && !block && !fault_q) begin
                cmd_q <= 2'h3;
                rel_q <= 1'b1;
            end else begin
                cmd_q <= test_pulse;
                rel_q <= 1'b0;           // release off keeps the coil dead while testing
            end
        end
    end

    // feedback check: after settling, an excited channel must read high
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            settle_q <= '0;
            exc_q    <= 2'h0;
            fault_q  <= 1'b0;
        end else if (clk_en) begin
            exc_q <= test_pulse;
            if (test_pulse == 2'h0 || test_pulse != exc_q) begin
                settle_q <= '0;
            end else if (settle_q < SETTLE[$bits(settle_q)-1:0]) begin
                settle_q <= settle_q + 1'b1;
            end else if ((feedback & exc_q) != exc_q) begin
                fault_q <= 1'b1;
            end
        end
    end

    assign cmd_out     = cmd_q & {2{~fault_q}};
    assign release_out = rel_q & ~fault_q;
    assign fault       = fault_q;
endmodule

// ==== rtl/rss_meas_chk.sv ====
// measurement chain checks: weighted zero sum and phase symmetry
`timescale 1ns/1ps
module rss_meas_chk #(
    parameter int unsigned W  = rss_pkg::SAMPLE_W,
    parameter int unsigned FW = rss_pkg::FACTOR_W
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire rss_pkg::rss_samp_t  samp,          // four signed samples
    input  wire logic [4*FW-1:0]     factor,        // summation factors
    input  wire logic [W-1:0]        sum_tol,       // zero-sum tolerance
    input  wire logic [W-1:0]        asym_th,       // asymmetry threshold
    input  wire logic                pickup,        // any element picked up
    output logic                     zsum_fail,     // one-cycle event
    output logic                     asym_fail      // one-cycle event
);
    localparam int unsigned PW = W + FW + 2;       // product and sum width
    logic signed [PW-1:0] acc;                     // weighted sum
    logic        [W-1:0]  mag [3];                 // phase magnitudes
    logic        [W-1:0]  mx;                      // largest phase
    logic        [W-1:0]  mn;                      // smallest phase
    logic signed [PW-1:0] sc;                      // scaled sum
    logic        [PW-1:0] sabs;                    // sum magnitude
    logic                 zs_q;                    // zero-sum result
    logic                 as_q;                    // asymmetry result

    // weighted sum and phase magnitudes
    always_comb begin
        acc = '0;
        for (int i = 0; i < 4; i++) begin
            acc = acc + PW'($signed(samp.data[i*W +: W]) *
                            $signed({1'b0, factor[i*FW +: FW]}));
        end
        for (int i = 0; i < 3; i++) begin
            mag[i] = samp.data[i*W+W-1] ? W'(-samp.data[i*W +: W]) : samp.data[i*W +: W];
        end
        mx = mag[0];
        mn = mag[0];
        for (int i = 1; i < 3; i++) begin
            if (mag[i] > mx) mx = mag[i];
            if (mag[i] < mn) mn = mag[i];
        end
        sc   = acc >>> rss_pkg::FACTOR_FRAC;
        sabs = sc[PW-1] ? PW'(-sc) : PW'(sc);
    end

    // register the check results per sample
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            zs_q <= 1'b0;
            as_q <= 1'b0;
        end else if (clk_en) begin
            zs_q <= samp.valid && (sabs > PW'(sum_tol));
            as_q <= samp.valid && !pickup && ((mx - mn) > asym_th);
        end
    end

    assign zsum_fail = zs_q;
    assign asym_fail = as_q;
endmodule

// ==== rtl/rss_top.sv ====
// relay self-supervision top: supplies, trip channels, measurement, memory, watchdog

`timescale 1ns/1ps
module rss_top #(
    parameter int unsigned WDOG_CYC = rss_pkg::WDOG_CYCLES,
    parameter int unsigned CYC_CYC  = rss_pkg::CYC_CYCLES,
    parameter int unsigned NUM_MEM  = 2
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,        // power-up reset
    input  wire logic                    clk_en,
    input  wire rss_pkg::rss_bus_t       bus,
    output logic [31:0]                  bus_rdata,
    input  wire logic [3:0]              rail_ok_pin,  // rail window comparators, async
    input  wire rss_pkg::rss_samp_t      samp,
    input  wire logic                    pickup,       // any protection element picked up
    input  wire logic [1:0]              trip_req,
    input  wire logic [3:0]              fb_pin,       // channel feedback, async
    output logic [3:0]                   trip_cmd,     // two per relay
    output logic [1:0]                   trip_release,
    input  wire logic [NUM_MEM-1:0]      mem_crc_valid, // checksum pass done
    input  wire logic [NUM_MEM*32-1:0]   mem_crc,      // computed checksums
    output logic [NUM_MEM-1:0]           mem_crc_start, // start a checksum pass
    output logic                         cpu_reset,    // processor reset pulse
    output logic                         prot_block,
    output logic                         alarm_contact,
    output logic                         alarm_led,
    output logic                         irq
);
    localparam int unsigned WDW = $clog2(WDOG_CYC + 1);
    localparam int unsigned CYW = $clog2(CYC_CYC + 1);

    // synchronisers for pin inputs
    logic [3:0] rail_s1_q, rail_s2_q, rail_s3_q;   // rail stages
    logic [3:0] rail_q;                            // agreed rail level

    logic [3:0] fb_s1_q, fb_s2_q, fb_s3_q;         // feedback stages
    logic [3:0] fb_q;                              // agreed feedback level

    // status and interrupts
    logic [rss_pkg::ST_W-1:0] status_q;            // sticky faults
    logic [rss_pkg::ST_W-1:0] enable_q;            // interrupt enables
    logic [rss_pkg::ST_W-1:0] event_d;             // this cycle's events
    logic [rss_pkg::ST_W-1:0] clr_d;               // this cycle's clears

    // software settings
    logic [15:0]              sum_tol_q;           // zero-sum tolerance
    logic [15:0]              asym_th_q;           // asymmetry threshold
    logic [31:0]              factor_q;            // summation factors
    logic [31:0]              crc_ref_q [NUM_MEM]; // reference checksums

    // read path
    logic [31:0]              rdata_q;             // read data
    logic                     rd_q;                // read in flight

    // cyclic test
    logic [CYW-1:0]           cyc_cnt_q;           // test step timer
    logic [1:0]               cyc_step_q;          // channel under excitation
    logic [3:0]               test_pulse;          // excitation per channel
    logic [1:0]               tch_fault;           // trip channel faults

    // events
    logic                     zsum_ev;
    logic                     asym_ev;
    logic                     mem_ev;
    logic                     wd_ev;

    // watchdog
    logic [WDW-1:0]           wd_cnt_q;            // watchdog counter
    logic [1:0]               attempts_q;          // reset attempts since power-up
    logic                     lock_q;              // out of service
    logic                     cpu_rst_q;

    // helpers
    logic [NUM_MEM-1:0]       crc_start_q;
    logic                     any_fault;
    logic                     wr_hit;

    // three-stage synchronisers, change accepted when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // rails start healthy
            rail_s1_q <= 4'hf;
            rail_s2_q <= 4'hf;
            rail_s3_q <= 4'hf;
            rail_q    <= 4'hf;
            fb_s1_q   <= 4'h0;
            fb_s2_q   <= 4'h0;
            fb_s3_q   <= 4'h0;
            fb_q      <= 4'h0;
        end else if (clk_en) begin
            // shift rails
            rail_s1_q <= rail_ok_pin;
            rail_s2_q <= rail_s1_q;
            rail_s3_q <= rail_s2_q;

            // accept on agreement
            for (int i = 0; i < 4; i++) begin
                if (rail_s2_q[i] == rail_s3_q[i]) rail_q[i] <= rail_s3_q[i];
            end

            // shift feedback
            fb_s1_q <= fb_pin;
            fb_s2_q <= fb_s1_q;
            fb_s3_q <= fb_s2_q;
            for (int i = 0; i < 4; i++) begin
                if (fb_s2_q[i] == fb_s3_q[i]) fb_q[i] <= fb_s3_q[i];
            end
        end
    end

    // register writes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // defaults
            enable_q  <= '0;
            sum_tol_q <= rss_pkg::SUMTOL_RST;
            asym_th_q <= rss_pkg::ASYMTH_RST;
            factor_q  <= rss_pkg::FACTOR_RST;
            for (int i = 0; i < NUM_MEM; i++) crc_ref_q[i] <= 32'h0;
        end else if (clk_en && bus.wr) begin
            case (bus.addr)
                rss_pkg::ADDR_ENABLE: enable_q  <= bus.wdata[rss_pkg::ST_W-1:0];
                rss_pkg::ADDR_SUMTOL: sum_tol_q <= bus.wdata[15:0];
                rss_pkg::ADDR_ASYMTH: asym_th_q <= bus.wdata[15:0];
                rss_pkg::ADDR_FACTOR: factor_q  <= bus.wdata;

                // reference checksums
                default: begin
                    for (int i = 0; i < NUM_MEM; i++) begin
                        if (bus.addr == 8'(rss_pkg::ADDR_CRCREF + 4 * i)) begin
                            crc_ref_q[i] <= bus.wdata;
                        end
                    end
                end
            endcase
        end
    end

    // register reads, data valid the cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
            rd_q    <= 1'b0;
        end else if (clk_en) begin
            // data stand one cycle
            rd_q    <= bus.rd;

            // idle reads zero
            rdata_q <= 32'h0;
            if (bus.rd) begin
                case (bus.addr)
                    rss_pkg::ADDR_STATUS: rdata_q <= 32'(status_q);
                    rss_pkg::ADDR_ENABLE: rdata_q <= 32'(enable_q);
                    rss_pkg::ADDR_SUMTOL: rdata_q <= 32'(sum_tol_q);
                    rss_pkg::ADDR_ASYMTH: rdata_q <= 32'(asym_th_q);
                    rss_pkg::ADDR_FACTOR: rdata_q <= factor_q;
                    rss_pkg::ADDR_STATE:  rdata_q <= {16'h0, fb_q, rail_q, attempts_q,
                                                      cyc_step_q, lock_q, prot_block,
                                                      tch_fault};
                    default: begin
                        for (int i = 0; i < NUM_MEM; i++) begin
                            if (bus.addr == 8'(rss_pkg::ADDR_CRCREF + 4 * i)) begin
                                rdata_q <= crc_ref_q[i];
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign bus_rdata = rd_q ? rdata_q : 32'h0;

    // cyclic excitation, one command channel per step, only while idle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cyc_cnt_q  <= '0;
            cyc_step_q <= 2'h0;
        end else if (clk_en) begin
            // busy: restart step
            if (pickup || trip_req != 2'h0) begin
                cyc_cnt_q <= '0;
            end else if (cyc_cnt_q >= CYW'(CYC_CYC - 1)) begin
                // next channel
                cyc_cnt_q  <= '0;
                cyc_step_q <= cyc_step_q + 2'h1;
            end else begin
                cyc_cnt_q <= cyc_cnt_q + 1'b1;
            end
        end
    end

    // excitation stays off during the last cycles so the next channel starts clean
    always_comb begin
        // nothing excited
        test_pulse = 4'h0;
        if (!pickup && trip_req == 2'h0 && cyc_cnt_q < CYW'(CYC_CYC - 2)) begin
            test_pulse[cyc_step_q] = 1'b1;
        end
    end

    // trip relay channels

    for (genvar g = 0; g < rss_pkg::NUM_TRIP; g++) begin : g_trip
        rss_trip_chan u_chan (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .clk_en      (clk_en),
            .trip_req    (trip_req[g]),
            .block       (prot_block),
            .test_pulse  (test_pulse[2*g +: 2]),
            .feedback    (fb_q[2*g +: 2]),
            .cmd_out     (trip_cmd[2*g +: 2]),
            .release_out (trip_release[g]),
            .fault       (tch_fault[g])
        );
    end

    // measurement chain checks
    rss_meas_chk u_meas (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .samp      (samp),
        .factor    (factor_q),
        .sum_tol   (sum_tol_q),
        .asym_th   (asym_th_q),
        .pickup    (pickup),
        .zsum_fail (zsum_ev),
        .asym_fail (asym_ev)
    );

    // memory checksum: restart each pass when it ends, compare with reference
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // first pass
            crc_start_q <= '1;
        end else if (clk_en) begin
            // next pass
            crc_start_q <= mem_crc_valid;
        end
    end

    // wrong sum
    always_comb begin
        mem_ev = 1'b0;
        for (int i = 0; i < NUM_MEM; i++) begin
            if (mem_crc_valid[i] && mem_crc[i*32 +: 32] != crc_ref_q[i]) begin
                mem_ev = 1'b1;
            end
        end
    end
    assign mem_crc_start = crc_start_q;

    // watchdog: key write services it, expiry pulses processor reset, or locks out once MAX_RESETS pulses are spent
    assign wr_hit = bus.wr && bus.addr == rss_pkg::ADDR_WDKICK
                    && bus.wdata == rss_pkg::WDKICK_KEY;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // power-up only
            wd_cnt_q   <= '0;
            cpu_rst_q  <= 1'b0;
            attempts_q <= 2'h0;
            lock_q     <= 1'b0;
        end else if (clk_en) begin
            cpu_rst_q <= 1'b0;
            // locked: quiet
            if (lock_q) begin
                wd_cnt_q <= '0;
            end else if (wr_hit) begin
                // serviced
                wd_cnt_q <= '0;
            end else if (wd_cnt_q >= WDW'(WDOG_CYC - 1)) begin
                // expired
                wd_cnt_q <= '0;
                if (attempts_q == 2'(rss_pkg::MAX_RESETS)) begin
                    lock_q <= 1'b1;
                end else begin
                    cpu_rst_q  <= 1'b1;
                    attempts_q <= attempts_q + 2'h1;
                end
            end else begin
                wd_cnt_q <= wd_cnt_q + 1'b1;
            end
        end
    end

    // expiry event
    assign wd_ev     = clk_en && !lock_q && !wr_hit && wd_cnt_q >= WDW'(WDOG_CYC - 1);
    assign cpu_reset = cpu_rst_q;

    // sticky status, set wins over clear
    always_comb begin
        // levels keep setting
        event_d = '0;
        event_d[rss_pkg::ST_SUPPLY] = rail_q != 4'hf;
        event_d[rss_pkg::ST_TRIPCH] = tch_fault != 2'h0;
        event_d[rss_pkg::ST_ZSUM]   = zsum_ev;
        event_d[rss_pkg::ST_ASYM]   = asym_ev;
        event_d[rss_pkg::ST_MEM]    = mem_ev;
        event_d[rss_pkg::ST_WDOG]   = wd_ev;
        event_d[rss_pkg::ST_LOCK]   = lock_q;

        // write one clears
        clr_d = (bus.wr && bus.addr == rss_pkg::ADDR_CLEAR) ?
                bus.wdata[rss_pkg::ST_W-1:0] : '0;
    end

    // set wins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_q <= '0;
        end else if (clk_en) begin
            status_q <= (status_q & ~clr_d) | event_d;
        end
    end

    // blocking and the alarm contact follow live faults plus sticky measurement and memory faults
    assign any_fault = (rail_q != 4'hf) || (tch_fault != 2'h0) || lock_q
                       || status_q[rss_pkg::ST_ZSUM] || status_q[rss_pkg::ST_MEM]
                       || status_q[rss_pkg::ST_ASYM];

    assign prot_block    = any_fault;
    assign alarm_contact = any_fault;

    // led: lockout, coil
    assign alarm_led     = lock_q || (tch_fault != 2'h0);

    // enabled sticky bits
    assign irq           = |(status_q & enable_q);
endmodule

// ==== testbench/rss_top_props.sv ====
// assertion checker on the self-supervision top ports
`timescale 1ns/1ps
module rss_top_props (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       pickup,
    input wire logic [1:0] trip_req,
    input wire logic [3:0] trip_cmd,
    input wire logic [1:0] trip_release,
    input wire logic [1:0] mem_crc_valid,
    input wire logic [1:0] mem_crc_start,
    input wire logic       cpu_reset,
    input wire logic       prot_block,
    input wire logic       alarm_contact,
    input wire logic       alarm_led
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // an element held picked up with no trip request
    sequence s_held;
        (pickup && trip_req == 2'b00) [*4];
    endsequence
    a_alarm_blocks: assert property (alarm_contact |-> prot_block)
        else $error("alarm without block");
    a_block_no_trip: assert property (prot_block [*3] |-> trip_release == 2'b00)
        else $error("release while blocked");
    a_release_needs_cmd: assert property ((trip_release[0] -> &trip_cmd[1:0])
        && (trip_release[1] -> &trip_cmd[3:2])) else $error("release without commands");
    a_pickup_no_test: assert property (s_held |-> trip_cmd == 4'h0)
        else $error("channel test during pickup");
    a_led_contact: assert property (alarm_led |-> alarm_contact)
        else $error("led without contact");
    a_led_sticky: assert property (alarm_led |=> alarm_led)
        else $error("led dropped");
    a_reset_pulse: assert property (cpu_reset |=> !cpu_reset)
        else $error("processor reset too long");
    a_crc_restart: assert property (mem_crc_valid[0] |=> mem_crc_start[0])
        else $error("checksum pass not restarted");
endmodule

// ==== testbench/rss_far_model.sv ====
// trip driver model: channel feedback echoes the command after a short lag
`timescale 1ns/1ps
module rss_far_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] trip_cmd,   // command channels from the block
    input  wire logic [3:0] open_coil,  // channels with a broken coil
    output logic      [3:0] fb_pin      // feedback seen by the block
);
    logic [3:0] lag_q;  // driver and coil response delay
    // healthy coils echo the command, a broken one reads low
    always_ff @(posedge core_clk) begin
        lag_q  <= trip_cmd;
        fb_pin <= lag_q & ~open_coil;
    end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the relay self-supervision top
`timescale 1ns/1ps
module testbench;
    logic               core_clk = 1'b0;
    logic               rst_n = 1'b0;
    rss_pkg::rss_bus_t  bus = '0;
    rss_pkg::rss_samp_t samp = '0;
    logic [31:0]        bus_rdata;
    logic [3:0]         rail_ok_pin = 4'hf, open_coil = 4'h0, fb_pin, trip_cmd;
    logic               pickup = 1'b0, cpu_reset, prot_block, alarm_contact, alarm_led, irq;
    logic [1:0]         trip_req = 2'h0, mem_crc_valid = 2'h0, mem_crc_start, trip_release;
    int                 num_errors = 0, checks = 0, pulses = 0;
    always #4 core_clk = ~core_clk;
    // count processor reset pulses
    always @(posedge core_clk) if (cpu_reset === 1'b1) pulses++;
    rss_top #(.WDOG_CYC(50), .CYC_CYC(40)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(1'b1), .bus(bus), .bus_rdata(bus_rdata), .rail_ok_pin(rail_ok_pin),
        .samp(samp), .pickup(pickup), .trip_req(trip_req), .fb_pin(fb_pin),
        .trip_cmd(trip_cmd), .trip_release(trip_release), .mem_crc_valid(mem_crc_valid),
        .mem_crc(64'h0), .mem_crc_start(mem_crc_start), .cpu_reset(cpu_reset),
        .prot_block(prot_block), .alarm_contact(alarm_contact), .alarm_led(alarm_led),
        .irq(irq));
    rss_far_model far (.core_clk(core_clk), .trip_cmd(trip_cmd), .open_coil(open_coil),
        .fb_pin(fb_pin));
    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk) bus.rd <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask
    // service the watchdog, then idle
    task automatic kk(input int n);
        wr(8'h18, rss_pkg::WDKICK_KEY);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic smp(input logic [63:0] d);
        @(posedge core_clk) samp <= '{1'b1, d};
        @(posedge core_clk) samp.valid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #40000 num_errors++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h0c, 32'h40);
        rd(8'h10, 32'h400);
        rd(8'h14, 32'h40404040);
        rd(8'hfc, 32'h0);
        wr(8'h00, 32'hff);
        rd(8'h00, 32'h0);
        wr(8'h08, 32'h7f);
        kk(1);
        smp(64'h0000_0064_0000_0000);
        chk(prot_block & alarm_contact & irq, 32'h1);
        rd(8'h00, 32'h4);
        wr(8'h08, 32'h0);
        #1 chk(irq, 32'h0);
        wr(8'h08, 32'h7f);
        wr(8'h04, 32'h4);
        #1 chk(irq, 32'h0);
        @(posedge core_clk) pickup <= 1'b1;
        smp(64'hf800_0000_0000_0800);
        rd(8'h00, 32'h0);
        @(posedge core_clk) pickup <= 1'b0;
        smp(64'hf800_0000_0000_0800);
        rd(8'h00, 32'h8);
        wr(8'h04, 32'h8);
        kk(1);
        @(posedge core_clk) trip_req <= 2'b01;
        repeat (3) @(posedge core_clk);
        #1 chk({trip_release[0], trip_cmd[1:0]}, 32'h7);
        @(posedge core_clk) trip_req <= 2'b00;
        wr(8'h20, 32'h1);
        @(posedge core_clk) mem_crc_valid <= 2'b01;
        @(posedge core_clk) mem_crc_valid <= 2'b00;
        rd(8'h00, 32'h10);
        wr(8'h04, 32'h10);
        kk(1);
        @(posedge core_clk) rail_ok_pin <= 4'hb;
        repeat (6) @(posedge core_clk);
        #1 chk(prot_block, 32'h1);
        rd(8'h00, 32'h1);
        @(posedge core_clk) rail_ok_pin <= 4'hf;
        repeat (6) @(posedge core_clk);
        wr(8'h04, 32'h1);
        rd(8'h00, 32'h0);
        kk(0);
        pulses = 0;
        repeat (260) @(posedge core_clk);
        chk(pulses, 32'h3);
        chk(alarm_led, 32'h1);
        rd(8'h00, 32'h60);
        @(posedge core_clk) rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        pulses = 0;
        repeat (60) @(posedge core_clk);
        chk({alarm_led, pulses[3:0]}, 32'h1);
        kk(1);
        wr(8'h04, 32'h20);
        @(posedge core_clk) open_coil <= 4'h4;
        repeat (12) kk(19);
        chk(alarm_led, 32'h1);
        rd(8'h00, 32'h2);
        @(posedge core_clk) trip_req <= 2'b10;
        repeat (3) @(posedge core_clk);
        #1 chk(trip_release, 32'h0);
        close_out();
    end
endmodule
bind rss_top rss_top_props u_props (.core_clk(core_clk), .rst_n(rst_n), .pickup(pickup),
    .trip_req(trip_req), .trip_cmd(trip_cmd), .trip_release(trip_release),
    .mem_crc_valid(mem_crc_valid), .mem_crc_start(mem_crc_start), .cpu_reset(cpu_reset),
    .prot_block(prot_block), .alarm_contact(alarm_contact), .alarm_led(alarm_led));
